// File: baseband_rate_irq_config.sv
module baseband_rate_irq_config (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic spi_sel_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  input wire logic code_half_select,
  input wire logic irq_assert,
  output logic irq_out,
  output logic irq_oe_n,
  output logic code_len_32,
  output logic double_rate,
  output logic oversample_12x,
  output logic code_split,
  output logic upper_half_sel,
  output logic dual_code_ok,
  output logic [1:0] bits_per_code,
  output logic [baseband_cfg_pkg::RATE_W-1:0] raw_rate_hbps,
  output logic invalid_cfg
);
  import baseband_cfg_pkg::*;

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                    input logic [ADDR_W-1:0] target);
    addr_hit = (a == target);
  endfunction : addr_hit

  logic [7:0] rate_select_reg;
  logic [7:0] irq_drive_cfg_reg;
  logic cmd_phase;
  logic write_cmd;
  logic [ADDR_W-1:0] addr;
  logic [7:0] rd_data;
  logic [7:0] rx_byte;
  logic byte_done;
  logic [7:0] next_rate_select_reg;
  logic [7:0] next_irq_drive_cfg_reg;
  logic next_cmd_phase;
  logic next_write_cmd;
  logic [ADDR_W-1:0] next_addr;
  logic [7:0] next_rd_data;

  spi_byte_shifter u_shifter (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .ce(ce),
    .sel_n(spi_sel_n),
    .sck(spi_sck),
    .mosi(spi_mosi),
    .tx_byte(rd_data),
    .rx_byte(rx_byte),
    .byte_done(byte_done),
    .miso(spi_miso)
  );

  // Host port: command byte, then data bytes with auto-increment
  always_comb begin
    next_rate_select_reg = rate_select_reg;
    next_irq_drive_cfg_reg = irq_drive_cfg_reg;
    next_cmd_phase = cmd_phase;
    next_write_cmd = write_cmd;
    next_addr = addr;
    if (spi_sel_n) begin
      next_cmd_phase = 1'b1;
    end else if (byte_done) begin
      if (cmd_phase) begin
        next_cmd_phase = 1'b0;
        next_write_cmd = rx_byte[CMD_WRITE_BIT];
        next_addr = rx_byte[ADDR_W-1:0];
      end else begin
        // Reserved bits are masked off, so stray ones never stick
        if (write_cmd && addr_hit(addr, RATE_SELECT_ADDR)) begin
          next_rate_select_reg = rx_byte & RATE_SELECT_MASK;
        end
        if (write_cmd && addr_hit(addr, IRQ_DRIVE_CFG_ADDR)) begin
          next_irq_drive_cfg_reg = rx_byte & IRQ_DRIVE_CFG_MASK;
        end
        next_addr = addr + 6'h01;
      end
    end
    next_rd_data = 8'h00;
    if (addr_hit(addr, RATE_SELECT_ADDR)) begin
      next_rd_data = rate_select_reg;
    end else if (addr_hit(addr, IRQ_DRIVE_CFG_ADDR)) begin
      next_rd_data = irq_drive_cfg_reg;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rate_select_reg <= RATE_SELECT_RESET;
      irq_drive_cfg_reg <= IRQ_DRIVE_CFG_RESET;
      cmd_phase <= 1'b1;
      write_cmd <= 1'b0;
      addr <= '0;
      rd_data <= 8'h00;
    end else if (ce) begin
      rate_select_reg <= next_rate_select_reg;
      irq_drive_cfg_reg <= next_irq_drive_cfg_reg;
      cmd_phase <= next_cmd_phase;
      write_cmd <= next_write_cmd;
      addr <= next_addr;
      rd_data <= next_rd_data;
    end
  end

  // Mode decode
  logic sel_32;
  logic sel_double;
  logic next_code_len_32;
  logic next_double_rate;
  logic next_oversample_12x;
  logic next_code_split;
  logic next_upper_half_sel;
  logic next_dual_code_ok;
  logic [1:0] next_bits_per_code;
  logic [RATE_W-1:0] next_raw_rate_hbps;
  logic next_invalid_cfg;

  always_comb begin
    sel_32 = rate_select_reg[CODE_LEN_BIT];
    sel_double = sel_32 & rate_select_reg[BITS_PER_CODE_BIT];
    next_code_len_32 = sel_32;
    next_double_rate = sel_double;
    next_code_split = sel_double;
    // 12x only in 32-chip normal rate
    next_oversample_12x = sel_32 & ~sel_double &
                          rate_select_reg[OVERSAMPLE_BIT];
    next_dual_code_ok = sel_32 & ~sel_double;
    // Both halves in use at double rate, so half select is moot
    next_upper_half_sel = sel_32 & ~sel_double & code_half_select;
    next_bits_per_code = sel_double ? TWO_BITS_PER_CODE
                                    : ONE_BIT_PER_CODE;
    if (sel_double) begin
      next_raw_rate_hbps = RATE_DOUBLE_HBPS;
    end else if (sel_32) begin
      next_raw_rate_hbps = RATE_32_NORMAL_HBPS;
    end else begin
      next_raw_rate_hbps = RATE_64_NORMAL_HBPS;
    end
    // Flag only; the device still runs 64-chip 6x
    next_invalid_cfg = (rate_select_reg[CODE_LEN_BIT:OVERSAMPLE_BIT] ==
                        INVALID_RATE_CODE);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      code_len_32 <= 1'b0;
      double_rate <= 1'b0;
      oversample_12x <= 1'b0;
      code_split <= 1'b0;
      upper_half_sel <= 1'b0;
      dual_code_ok <= 1'b0;
      bits_per_code <= ONE_BIT_PER_CODE;
      raw_rate_hbps <= RATE_64_NORMAL_HBPS;
      invalid_cfg <= 1'b0;
    end else if (ce) begin
      code_len_32 <= next_code_len_32;
      double_rate <= next_double_rate;
      oversample_12x <= next_oversample_12x;
      code_split <= next_code_split;
      upper_half_sel <= next_upper_half_sel;
      dual_code_ok <= next_dual_code_ok;
      bits_per_code <= next_bits_per_code;
      raw_rate_hbps <= next_raw_rate_hbps;
      invalid_cfg <= next_invalid_cfg;
    end
  end

  // Interrupt pin drive
  logic next_irq_out;
  logic next_irq_oe_n;
  logic next_miso_oe_n;
  irq_drive_t drive_mode;

  always_comb begin
    drive_mode = irq_drive_t'(irq_drive_cfg_reg[1:0]);
    next_miso_oe_n = spi_sel_n;
    case (drive_mode)
      IRQ_OPEN_SOURCE: begin
        next_irq_out = 1'b1;
        next_irq_oe_n = ~irq_assert;
      end
      IRQ_OPEN_DRAIN: begin
        next_irq_out = 1'b0;
        next_irq_oe_n = ~irq_assert;
      end
      IRQ_CMOS: begin
        next_irq_out = irq_assert;
        next_irq_oe_n = 1'b0;
      end
      IRQ_CMOS_INVERTED: begin
        next_irq_out = ~irq_assert;
        next_irq_oe_n = 1'b0;
      end
      default: begin
        next_irq_out = irq_assert;
        next_irq_oe_n = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
      irq_oe_n <= 1'b0;
      spi_miso_oe_n <= 1'b1;
    end else if (ce) begin
      irq_out <= next_irq_out;
      irq_oe_n <= next_irq_oe_n;
      spi_miso_oe_n <= next_miso_oe_n;
    end
  end
endmodule : baseband_rate_irq_config

// File: baseband_cfg_pkg.sv
package baseband_cfg_pkg;
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] RATE_SELECT_ADDR = 6'h04;
  localparam logic [ADDR_W-1:0] IRQ_DRIVE_CFG_ADDR = 6'h05;
  localparam logic [7:0] RATE_SELECT_RESET = 8'h00;
  localparam logic [7:0] IRQ_DRIVE_CFG_RESET = 8'h01;
  // Writable bits; reserved bits read back as zero
  localparam logic [7:0] RATE_SELECT_MASK = 8'h07;
  localparam logic [7:0] IRQ_DRIVE_CFG_MASK = 8'h03;
  localparam int CODE_LEN_BIT = 2;
  localparam int BITS_PER_CODE_BIT = 1;
  localparam int OVERSAMPLE_BIT = 0;
  // Command byte layout
  localparam int CMD_WRITE_BIT = 7;
  localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
  localparam logic [2:0] BYTE_FIRST_BIT = 3'h0;
  localparam logic [2:0] INVALID_RATE_CODE = 3'h1;
  // Raw data rates in units of 100 bit/s
  localparam int RATE_W = 10;
  localparam logic [RATE_W-1:0] RATE_DOUBLE_HBPS = 10'h271;
  localparam logic [RATE_W-1:0] RATE_32_NORMAL_HBPS = 10'h140;
  localparam logic [RATE_W-1:0] RATE_64_NORMAL_HBPS = 10'h0a0;
  localparam logic [1:0] ONE_BIT_PER_CODE = 2'h1;
  localparam logic [1:0] TWO_BITS_PER_CODE = 2'h2;

  typedef enum logic [1:0] {
    IRQ_CMOS_INVERTED,
    IRQ_CMOS,
    IRQ_OPEN_DRAIN,
    IRQ_OPEN_SOURCE
  } irq_drive_t;
endpackage : baseband_cfg_pkg

// File: spi_byte_shifter.sv
module spi_byte_shifter (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic sel_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic [7:0] tx_byte,
  output logic [7:0] rx_byte,
  output logic byte_done,
  output logic miso
);
  import baseband_cfg_pkg::*;

  logic sck_prev;
  logic [2:0] bit_cnt;
  logic [7:0] shift_in;
  logic [7:0] shift_out;
  logic [2:0] next_bit_cnt;
  logic [7:0] next_shift_in;
  logic [7:0] next_shift_out;
  logic [7:0] next_rx_byte;
  logic next_byte_done;
  logic rise;
  logic fall;

  assign rise = sck & ~sck_prev;
  assign fall = ~sck & sck_prev;
  assign miso = shift_out[7];

  always_comb begin
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_rx_byte = rx_byte;
    next_byte_done = 1'b0;
    if (sel_n) begin
      next_bit_cnt = BYTE_FIRST_BIT;
      next_shift_out = 8'h00;
    end else begin
      if (rise) begin
        next_shift_in = {shift_in[6:0], mosi};
        next_bit_cnt = bit_cnt + 3'h1;
        if (bit_cnt == BYTE_LAST_BIT) begin
          next_rx_byte = {shift_in[6:0], mosi};
          next_byte_done = 1'b1;
        end
      end
      // Mode 0: next bit goes out on the falling edge
      if (fall) begin
        if (bit_cnt == BYTE_FIRST_BIT) begin
          next_shift_out = tx_byte;
        end else begin
          next_shift_out = {shift_out[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sck_prev <= 1'b0;
      bit_cnt <= BYTE_FIRST_BIT;
      shift_in <= 8'h00;
      shift_out <= 8'h00;
      rx_byte <= 8'h00;
      byte_done <= 1'b0;
    end else if (ce) begin
      sck_prev <= sck;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      rx_byte <= next_rx_byte;
      byte_done <= next_byte_done;
    end
  end
endmodule : spi_byte_shifter

// File: baseband_rate_irq_config_chk.sv
module baseband_rate_irq_config_chk (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic spi_sel_n,
  input wire logic spi_miso_oe_n,
  input wire logic irq_assert,
  input wire logic irq_out,
  input wire logic irq_oe_n,
  input wire logic code_len_32,
  input wire logic double_rate,
  input wire logic oversample_12x,
  input wire logic code_split,
  input wire logic upper_half_sel,
  input wire logic dual_code_ok,
  input wire logic [1:0] bits_per_code,
  input wire logic [baseband_cfg_pkg::RATE_W-1:0] raw_rate_hbps,
  input wire logic invalid_cfg
);
  import baseband_cfg_pkg::*;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_req_rise;
    !irq_assert ##1 irq_assert;
  endsequence
  a_split_double: assert property (code_split == double_rate)
    else $error("code split differs from double rate");
  a_double_32: assert property (double_rate |-> code_len_32)
    else $error("double rate with long codes");
  a_os_normal: assert property (oversample_12x |-> dual_code_ok)
    else $error("fine sampling outside short normal mode");
  a_bpc_rate: assert property (bits_per_code ==
    (double_rate ? TWO_BITS_PER_CODE : ONE_BIT_PER_CODE))
    else $error("bits per code wrong");
  a_raw_rate: assert property (raw_rate_hbps == (double_rate ?
    RATE_DOUBLE_HBPS : code_len_32 ? RATE_32_NORMAL_HBPS :
    RATE_64_NORMAL_HBPS)) else $error("raw rate wrong");
  a_dual_code: assert property (dual_code_ok == (code_len_32 && !double_rate))
    else $error("dual code flag wrong");
  a_upper_half: assert property (upper_half_sel |-> dual_code_ok)
    else $error("half select outside short normal mode");
  a_invalid_safe: assert property (invalid_cfg |-> !code_len_32 &&
    !oversample_12x) else $error("invalid pattern not long 6x");
  a_irq_drives: assert property ((ce throughout s_req_rise) |=> !irq_oe_n)
    else $error("irq pin not driven when asserted");
  a_reset_mode: assert property ($rose(rst_n) |-> !code_len_32 &&
    !double_rate && !oversample_12x) else $error("reset mode");
  a_miso_enable: assert property (ce |=> spi_miso_oe_n == $past(spi_sel_n))
    else $error("miso enable does not follow select");
  a_ce_hold: assert property (!ce |=> $stable(irq_out) && $stable(irq_oe_n))
    else $error("irq pin moved while clock enable low");
endmodule : baseband_rate_irq_config_chk

bind baseband_rate_irq_config baseband_rate_irq_config_chk i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .ce(ce), .irq_assert(irq_assert),
  .spi_sel_n(spi_sel_n), .spi_miso_oe_n(spi_miso_oe_n), .irq_out(irq_out),
  .irq_oe_n(irq_oe_n), .code_len_32(code_len_32),
  .double_rate(double_rate), .oversample_12x(oversample_12x),
  .code_split(code_split), .upper_half_sel(upper_half_sel),
  .dual_code_ok(dual_code_ok), .bits_per_code(bits_per_code),
  .raw_rate_hbps(raw_rate_hbps), .invalid_cfg(invalid_cfg)
);

// File: spi_host_model.sv
module spi_host_model (
  input wire logic core_clk,
  output logic sel_n,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sel_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask : tick
  // Four-cycle phases: the core needs three to turn a command byte into read data
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      tick(4);
      rx[i] = miso;
      sck = 1'b1;
      tick(4);
      sck = 1'b0;
    end
  endtask : xfer
  task automatic frame(input logic [7:0] cmd, input logic [7:0] tx[$],
                       output logic [7:0] rx[$]);
    logic [7:0] b;
    rx = {};
    sel_n = 1'b0;
    xfer(cmd, b);
    foreach (tx[i]) begin
      xfer(tx[i], b);
      rx.push_back(b);
    end
    tick(4);
    sel_n = 1'b1;
    // Released line must not keep its last value
    mosi = ~mosi;
    tick(4);
  endtask : frame
endmodule : spi_host_model

// File: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import baseband_cfg_pkg::*;
  logic core_clk = 1'b0, rst_n = 1'b0, half = 1'b0, req = 1'b0, ce = 1'b1;
  logic sel_n, sck, mosi, miso, m_oe, i_out, i_oe, l32, dbl, os, spl;
  logic up, dual, inv;
  logic [1:0] bpc;
  logic [RATE_W-1:0] rate;
  logic [7:0] rate_m = 8'h00, irq_m = 8'h01;
  logic [7:0] rq[$];
  int err_total = 0, checks = 0;
  always #50 core_clk = ~core_clk;
  baseband_rate_irq_config i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .ce(ce), .spi_sel_n(sel_n), .spi_sck(sck), .spi_mosi(mosi),
    .spi_miso(miso), .spi_miso_oe_n(m_oe), .code_half_select(half),
    .irq_assert(req), .irq_out(i_out), .irq_oe_n(i_oe), .code_len_32(l32),
    .double_rate(dbl), .oversample_12x(os), .code_split(spl),
    .upper_half_sel(up), .dual_code_ok(dual), .bits_per_code(bpc),
    .raw_rate_hbps(rate), .invalid_cfg(inv));
  spi_host_model i_host (.core_clk(core_clk), .sel_n(sel_n), .sck(sck),
    .mosi(mosi), .miso(m_oe ? ~mosi : miso));
  task automatic check(input string what, input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [7:0] q[$];
    q.push_back(d);
    i_host.frame({2'b10, a}, q, rq);
    if (a == 6'h04) rate_m = d & 8'h07;
    if (a == 6'h05) irq_m = d & 8'h03;
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    logic [7:0] q[$];
    q.push_back(8'h00);
    i_host.frame({2'b00, a}, q, rq);
    d = rq[0];
  endtask : rd
  task automatic chk_status;
    logic s, b, n;
    s = rate_m[2];
    b = s & rate_m[1];
    n = s & !b;
    check("code_len_32", l32, s);
    check("double_rate", dbl, b);
    check("bits_per_code", bpc, b ? 2'h2 : 2'h1);
    check("code_split", spl, b);
    check("raw_rate", rate, b ? 10'h271 : s ? 10'h140 : 10'h0a0);
    check("dual_code", dual, n);
    check("oversample", os, n & rate_m[0]);
    check("upper_half", up, n & half);
    check("invalid", inv, rate_m[2:0] == 3'h1);
  endtask : chk_status
  initial begin
    logic [7:0] d;
    logic [31:0] r;
    logic [7:0] q[$];
    void'($urandom(32'he965));
    repeat (6) @(posedge core_clk);
    #5 rst_n = 1'b1;
    i_host.tick(1);
    chk_status;
    rd(6'h05, d);
    check("irq_reset", d, 8'h01);
    for (int p = 0; p < 8; p++) begin
      r = $urandom;
      half = r[0];
      wr(6'h04, {r[7:3], p[2:0]});
      chk_status;
      rd(6'h04, d);
      check("rate_rb", d, rate_m);
    end
    wr(6'h3a, 8'hff);
    rd(6'h3a, d);
    check("unmapped", d, 8'h00);
    q = {8'h05, 8'hfe};
    i_host.frame(8'h84, q, rq);
    rate_m = 8'h05;
    irq_m = 8'h02;
    chk_status;
    rd(6'h05, d);
    check("irq_rb", d, irq_m);
    for (int m = 3; m >= 0; m--) begin
      wr(6'h05, m[7:0]);
      repeat (4) begin
        req = 1'($urandom);
        i_host.tick(2);
        check("irq_out", i_out,
          m == 3 ? 1'b1 : m == 2 ? 1'b0 : m[0] ? req : !req);
        check("irq_oe_n", i_oe, m > 1 ? !req : 1'b0);
      end
    end
    // Frozen core must ignore the request change
    ce = 1'b0;
    d = {7'h00, i_out};
    req = ~req;
    i_host.tick(3);
    check("ce_hold", i_out, d[0]);
    ce = 1'b1;
    i_host.tick(2);
    check("ce_run", i_out, !req);
    rst_n = 1'b0;
    i_host.tick(2);
    rst_n = 1'b1;
    rate_m = RATE_SELECT_RESET;
    irq_m = IRQ_DRIVE_CFG_RESET;
    i_host.tick(1);
    chk_status;
    check("irq_rst", i_out, req);
    check("miso_oe_rst", m_oe, 1'b1);
    rd(6'h04, d);
    check("rate_rst", d, rate_m);
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_total++;
    end_of_test;
  end
endmodule : testbench
